// >>> tb/comparator_and_analog_pin_mux_test.sv
// Self-checking bench of the comparator and analog pin mux.
`timescale 1ns/100ps

module comparator_and_analog_pin_mux_test;
  import pin_mux_pkg::*;
  logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0, i_avs_from_ctrl_cpu = 1'b0;
  logic [5:0]  i_avs_address = 6'h00, i_comparator_result = 6'h2d, i_ana_dio_in = 6'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rdat;
  logic [7:0]  i_dig_pin_in = 8'h5a, o_dig_pin_out, o_dig_pin_oe, o_dig_pullup_en;
  logic [5:0]  o_ana_dio_out, o_ana_dio_oe, o_ana_to_comparator;
  logic [11:0] o_ana_to_converter;
  logic        o_avs_waitrequest;
  int          failures = 0, n_checks = 0;
  logic [31:0] rst_v [8] = '{32'h0, 32'hff, 32'h5a, 32'h0, 32'haaaaaaaa, 32'h0, 32'h0, 32'h0};
  logic [7:0]  eo [4] = '{8'hff, 8'h00, 8'h00, 8'hbe}; // Driven pins per mode.
  logic [7:0]  ev [4] = '{8'ha5, 8'h00, 8'h00, 8'h36}; // Driven values per mode.

  always #12.5 i_sys_clk = ~i_sys_clk;

  // Byte lanes are tied to full words, which keeps the checker shadows exact.
  comparator_and_analog_pin_mux dut_u (.i_sys_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_byteenable(4'hf), .i_avs_writedata, .i_avs_from_ctrl_cpu, .o_avs_readdata, .o_avs_waitrequest,
    .i_dig_pin_in, .i_comparator_result, .o_dig_pin_out, .o_dig_pin_oe, .o_dig_pullup_en, .i_ana_dio_in,
    .o_ana_dio_out, .o_ana_dio_oe, .o_ana_to_converter, .o_ana_to_comparator);

  // ==========================================================================
  // Bus and compare tasks.
  // ==========================================================================
  task automatic err(input string m);
    failures++;
    $display("ERROR at %0t: %s", $time, m);
  endtask : err

  // One Avalon access; the request holds until waitrequest is seen low.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic c);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_avs_read <= ~w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_from_ctrl_cpu <= c;
    // Waitrequest and read data are taken at the rising edge, before it updates them.
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) err("no bus answer");
    rdat = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask : wr

  task automatic chk_reg(input logic [5:0] a, input logic [31:0] e, input logic c);
    bus(1'b0, a, 32'h0, c);
    n_checks++;
    if (rdat !== e) err($sformatf("read %h got %h want %h", a, rdat, e));
  endtask : chk_reg

  task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) err($sformatf("pins got %h want %h", g, e));
  endtask : chk_pin

  // Pin outputs land one cycle after the register, so three cycles is ample.
  task automatic settle;
    repeat (3) @(negedge i_sys_clk);
  endtask : settle

  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Tests.
  // ==========================================================================
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    settle;
    chk_pin(32'(o_dig_pin_oe | o_dig_pullup_en), 32'h0);
    chk_pin(32'(o_ana_to_converter), 32'hfff);
    chk_pin(32'(o_ana_to_comparator), 32'h3f);
    for (int i = 0; i < 8; i++) chk_reg(6'(4 * i), rst_v[i], 1'b1);
    chk_reg(6'h20, 32'h0, 1'b1);
    $display("test reset done");
    wr(ADDR_DIG_PUD, 32'h3c);
    bus(1'b1, ADDR_DIG_PUD, 32'hff, 1'b0);
    settle;
    chk_pin(32'(o_dig_pullup_en), 32'hc3);
    chk_reg(ADDR_DIG_PUD, 32'h0, 1'b0);
    chk_reg(ADDR_DIG_PUD, 32'h3c, 1'b1);
    $display("test pullup done");
    wr(ADDR_DIG_ENABLE, 32'hff);
    wr(ADDR_DIG_DIR, 32'h0f);
    wr(ADDR_DIG_DATA, 32'ha5);
    settle;
    chk_pin(32'(o_dig_pin_oe), 32'h0f);
    chk_pin(32'(o_dig_pin_out & o_dig_pin_oe), 32'h05);
    chk_reg(ADDR_DIG_DATA, 32'h55, 1'b1);
    chk_reg(ADDR_DIG_DIR, 32'h0f, 1'b1);
    $display("test gpio done");
    wr(ADDR_DIG_DIR, 32'hff);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_DIG_FUNC_SEL, 32'({8{2'(m)}}));
      settle;
      chk_pin(32'(o_dig_pin_oe), 32'(eo[m]));
      chk_pin(32'(o_dig_pin_out & o_dig_pin_oe), 32'(ev[m]));
      chk_reg(ADDR_DIG_FUNC_SEL, 32'({8{2'(m)}}), 1'b1);
    end
    @(posedge i_sys_clk);
    i_comparator_result <= 6'h12;
    settle;
    chk_pin(32'(o_dig_pin_out & o_dig_pin_oe), 32'h88);
    wr(ADDR_DIG_FUNC_SEL, 32'h30);
    settle;
    chk_pin(32'(o_dig_pin_oe), 32'hff);
    chk_pin(32'(o_dig_pin_out), 32'ha1);
    @(posedge i_sys_clk);
    i_comparator_result <= 6'h20;
    settle;
    chk_pin(32'(o_dig_pin_out), 32'ha5);
    $display("test modes done");
    wr(ADDR_ANA_FUNC_SEL, 32'hffffffdf);
    settle;
    chk_pin(32'(o_ana_to_converter), 32'hffd);
    chk_pin(32'(o_ana_to_comparator), 32'h3e);
    chk_reg(ADDR_ANA_FUNC_SEL, 32'haaaaaa8a, 1'b1);
    wr(ADDR_ANA_DIR, 32'h3f);
    wr(ADDR_ANA_DATA, 32'h2b);
    settle;
    chk_pin(32'(o_ana_dio_oe), 32'h01);
    chk_pin(32'(o_ana_dio_out & o_ana_dio_oe), 32'h01);
    chk_reg(ADDR_ANA_DATA, 32'h01, 1'b1);
    wr(ADDR_ANA_FUNC_SEL, 32'h0);
    settle;
    chk_pin(32'(o_ana_to_converter | o_ana_to_comparator), 32'h0);
    chk_pin(32'(o_ana_dio_out & o_ana_dio_oe), 32'h2b);
    chk_reg(ADDR_ANA_DIR, 32'h3f, 1'b1);
    chk_reg(ADDR_ANA_DATA, 32'h2b, 1'b1);
    $display("test analog done");
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    settle;
    chk_pin(32'(o_dig_pin_oe), 32'h0);
    chk_pin(32'(o_ana_to_converter), 32'hfff);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    chk_reg(ADDR_DIG_PUD, 32'hff, 1'b1);
    chk_reg(ADDR_ANA_FUNC_SEL, 32'haaaaaaaa, 1'b1);
    $display("test second reset done");
    complete_run;
  end

  // The tests need well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err("watchdog expired");
    complete_run;
  end
endmodule : comparator_and_analog_pin_mux_test

bind comparator_and_analog_pin_mux pin_mux_checker chk_u (.i_sys_clk, .i_rst_n, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_avs_byteenable, .i_avs_writedata, .i_avs_from_ctrl_cpu, .o_avs_readdata, .o_avs_waitrequest,
  .i_dig_pin_in, .i_comparator_result, .o_dig_pin_out, .o_dig_pin_oe, .o_dig_pullup_en, .i_ana_dio_in,
  .o_ana_dio_out, .o_ana_dio_oe, .o_ana_to_converter, .o_ana_to_comparator);

// >>> tb/pin_mux_checker.sv
// Concurrent checks on the ports of the pin mux.
`timescale 1ns/100ps

module pin_mux_checker
  import pin_mux_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic        i_avs_from_ctrl_cpu,
  input  wire logic [31:0] o_avs_readdata,
  input  wire logic        o_avs_waitrequest,
  input  wire logic [7:0]  i_dig_pin_in,
  input  wire logic [5:0]  i_comparator_result,
  input  wire logic [7:0]  o_dig_pin_out,
  input  wire logic [7:0]  o_dig_pin_oe,
  input  wire logic [7:0]  o_dig_pullup_en,
  input  wire logic [5:0]  i_ana_dio_in,
  input  wire logic [5:0]  o_ana_dio_out,
  input  wire logic [5:0]  o_ana_dio_oe,
  input  wire logic [11:0] o_ana_to_converter,
  input  wire logic [5:0]  o_ana_to_comparator
);
  // ==========================================================================
  // Shadows of the mode registers, rebuilt from accepted full-word writes.
  // ==========================================================================
  logic        acc_w;   // Accepted control-CPU write.
  logic [15:0] sel_q;   // Digital mode fields.
  logic [11:0] conv_q;  // Converter switches implied by the odd select bits.
  logic [7:0]  rsvd_m;  // Pins in a reserved mode.
  logic [7:0]  m3_m;    // Pins in comparator mode.
  logic [7:0]  cmp_m;   // Comparator result expected on each pin.
  logic [31:0] wd;      // Short name for the write data.

  assign wd = i_avs_writedata;
  assign acc_w = i_avs_write && !o_avs_waitrequest && i_avs_from_ctrl_cpu && i_avs_byteenable == 4'hf;
  assign cmp_m = {i_comparator_result[4], 1'b0, i_comparator_result[3:1], i_comparator_result[5],
                  i_comparator_result[0], 1'b0};

  // The shadows load one cycle after the register, as the outputs do, so both are compared in the same cycle.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q  <= 16'h0000;
      conv_q <= 12'hfff;
    end else if (acc_w && i_avs_address == ADDR_DIG_FUNC_SEL) begin
      sel_q <= wd[15:0];
    end else if (acc_w && i_avs_address == ADDR_ANA_FUNC_SEL) begin
      conv_q <= {wd[31], wd[29], wd[25], wd[23], wd[21], wd[17], wd[15], wd[13], wd[9], wd[7], wd[5], wd[1]};
    end
  end

  // Per-pin mode masks.
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      rsvd_m[p] = sel_q[2*p +: 2] == MODE_RSVD1 || sel_q[2*p +: 2] == MODE_RSVD2;
      m3_m[p]   = sel_q[2*p +: 2] == MODE_COMP;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr(logic [5:0] a);
    acc_w && i_avs_address == a;
  endsequence
  sequence s_foreign;
    i_avs_write && !o_avs_waitrequest && !i_avs_from_ctrl_cpu;
  endsequence

  property p_reset;
    $rose(i_rst_n) |-> o_dig_pin_oe == 8'h00 && o_dig_pullup_en == 8'h00 && o_ana_dio_oe == 6'h00
      && o_ana_to_converter == 12'hfff && o_ana_to_comparator == 6'h3f;
  endproperty
  property p_pud;
    s_wr(ADDR_DIG_PUD) |=> ##1 o_dig_pullup_en == ~$past(i_avs_writedata[7:0], 2);
  endproperty
  property p_foreign;
    s_foreign |=> ##1 $stable(o_dig_pullup_en) && $stable(o_dig_pin_oe) && $stable(o_ana_to_converter);
  endproperty
  property p_rsvd;
    (o_dig_pin_oe & rsvd_m) == 8'h00;
  endproperty
  property p_comp;
    $past(i_comparator_result) == $past(i_comparator_result, 2) |->
      ((o_dig_pin_out ^ $past(cmp_m)) & o_dig_pin_oe & m3_m) == 8'h00
      && (o_dig_pin_oe & m3_m & 8'h41) == 8'h00;
  endproperty
  property p_ana_sel;
    s_wr(ADDR_ANA_FUNC_SEL) |=> ##1 o_ana_to_converter == conv_q;
  endproperty
  property p_ana_pair;
    o_ana_to_comparator == {o_ana_to_converter[10:9], o_ana_to_converter[7], o_ana_to_converter[4:3],
                            o_ana_to_converter[1]};
  endproperty
  property p_ana_oe;
    (o_ana_dio_oe & o_ana_to_comparator) == 6'h00;
  endproperty

  a_reset: assert property (p_reset) else $error("pins not in analog state after reset");
  a_pud: assert property (p_pud) else $error("pullup enables do not follow disable bits");
  a_foreign: assert property (p_foreign) else $error("foreign write changed pin setup");
  a_rsvd: assert property (p_rsvd) else $error("reserved mode drives a pin");
  a_comp: assert property (p_comp) else $error("comparator routing wrong");
  a_ana_sel: assert property (p_ana_sel) else $error("converter switches not from odd bits");
  a_ana_pair: assert property (p_ana_pair) else $error("comparator and converter paths differ");
  a_ana_oe: assert property (p_ana_oe) else $error("analog pin driven in analog mode");
endmodule : pin_mux_checker

// >>> verilog/comparator_and_analog_pin_mux.sv
// Pin mux for the comparator digital group and the first analog group.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/100ps

module comparator_and_analog_pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic        i_sys_clk,           // 40 MHz system clock.
  input  wire logic        i_rst_n,             // Asynchronous reset, low.
  // Avalon-MM slave.
  input  wire logic [5:0]  i_avs_address,       // Byte address.
  input  wire logic        i_avs_read,          // Read strobe.
  input  wire logic        i_avs_write,         // Write strobe.
  input  wire logic [3:0]  i_avs_byteenable,    // Byte lanes.
  input  wire logic [31:0] i_avs_writedata,     // Write data.
  input  wire logic        i_avs_from_ctrl_cpu, // Master is the control CPU.
  output logic      [31:0] o_avs_readdata,      // Read data.
  output logic             o_avs_waitrequest,   // Stall the master.
  // Digital group.
  input  wire logic [7:0]  i_dig_pin_in,        // Pin levels.
  input  wire logic [5:0]  i_comparator_result, // Comparators 1..6.
  output logic      [7:0]  o_dig_pin_out,       // Pin drive values.
  output logic      [7:0]  o_dig_pin_oe,        // Pin drive enables.
  output logic      [7:0]  o_dig_pullup_en,     // Pullup enables.
  // Analog group.
  input  wire logic [5:0]  i_ana_dio_in,        // Digital pin levels.
  output logic      [5:0]  o_ana_dio_out,       // Digital drive values.
  output logic      [5:0]  o_ana_dio_oe,        // Digital drive enables.
  output logic      [11:0] o_ana_to_converter,  // Converter switches.
  output logic      [5:0]  o_ana_to_comparator  // Comparator switches.
);

  // ==========================================================================
  // Helper functions.
  // ==========================================================================

  // Merges write data into an old value under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Spreads a channel mode vector onto the odd bits of a word.
  function automatic logic [31:0] odd_spread(input logic [15:0] m);
    logic [31:0] res;
    res = 32'h0000_0000;
    for (int c = 0; c < ANA_CHANS; c++) begin
      res[2*c+1] = m[c];
    end
    return res;
  endfunction : odd_spread

  // Gathers the odd bits of a word into a channel mode vector.
  function automatic logic [15:0] odd_gather(input logic [31:0] w);
    logic [15:0] res;
    res = 16'h0000;
    for (int c = 0; c < ANA_CHANS; c++) begin
      res[c] = w[2*c+1];
    end
    return res;
  endfunction : odd_gather

  // Read-back of a pin: latch while driven, pin level otherwise.
  function automatic logic [7:0] readback(input logic [7:0] drv,
                                          input logic [7:0] dat,
                                          input logic [7:0] pin);
    return (drv & dat) | (~drv & pin);
  endfunction : readback

  // ==========================================================================
  // State.
  // ==========================================================================
  state_type   s_q;  // Registered state.
  state_type   s_d;  // Next state.
  bus_req_type req;  // Bus request gathered.

  // Bus request as one carrier.
  always_comb begin
    req.read       = i_avs_read;
    req.write      = i_avs_write;
    req.address    = i_avs_address;
    req.byteenable = i_avs_byteenable;
    req.writedata  = i_avs_writedata;
    req.from_ctrl  = i_avs_from_ctrl_cpu;
  end

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================

  // One wait cycle per access keeps read data registered: the answer
  // is prepared in the first cycle and stands at the accepting edge.
  always_comb begin
    logic        take;     // Request in its first cycle, while waitrequest is high.
    logic        mapped;   // Address hits a register.
    logic        allowed;  // Write may change configuration.
    logic [31:0] wv;       // Merged write value.
    logic [31:0] rv;       // Read value.
    logic [7:0]  dig_gpio; // Pins in enabled mode 0.
    logic [7:0]  dig_drv;  // Pins driven from the latch.
    logic [5:0]  ana_dig;  // Analog pins in digital mode.
    logic [5:0]  ana_drv;  // Analog pins driven from the latch.
    logic [1:0]  mode;     // Mode of one digital pin.
    logic [2:0]  cmp;      // Comparator of one digital pin.
    logic [3:0]  ch;       // Channel of one analog pin.
    take     = 1'b0;
    mapped   = 1'b0;
    allowed  = 1'b0;
    wv       = 32'h0000_0000;
    rv       = 32'h0000_0000;
    dig_gpio = 8'h00;
    dig_drv  = 8'h00;
    ana_dig  = 6'h00;
    ana_drv  = 6'h00;
    mode     = MODE_GPIO;
    cmp      = COMP_NONE;
    ch       = 4'h0;
    s_d      = s_q;

    // Pins are sampled each cycle; inputs are synchronous.
    s_d.dig_in = i_dig_pin_in;
    s_d.ana_in = i_ana_dio_in;

    // Decode which pins act as plain digital I/O.
    for (int p = 0; p < DIG_PINS; p++) begin
      dig_gpio[p] = s_q.dig_en[p] && (s_q.dig_sel[2*p +: 2] == MODE_GPIO);
    end
    dig_drv = dig_gpio & s_q.dig_dir;
    for (int j = 0; j < ANA_DIOS; j++) begin
      ana_dig[j] = !s_q.ana_mode[ANA_DIO_CHAN[4*j +: 4]];
    end
    ana_drv = ana_dig & s_q.ana_dir;

    // Bus handshake: answer in the second cycle of each request.
    take  = (req.read || req.write) && !s_q.ack;
    s_d.ack = take;
    mapped  = (req.address[5] == 1'b0) && (req.address[1:0] == 2'h0);
    // A foreign master still gets an answer, but changes nothing.
    allowed = take && req.write && mapped && req.from_ctrl;

    // Read data, prepared one cycle ahead of the accepting edge.
    if (take && req.read && mapped && req.from_ctrl) begin
      case (req.address)
        ADDR_DIG_FUNC_SEL: rv = {16'h0000, s_q.dig_sel};
        ADDR_DIG_PUD:      rv = {24'h00_0000, s_q.dig_pud};
        ADDR_DIG_DATA:     rv = {24'h00_0000, readback(dig_drv, s_q.dig_dat, s_q.dig_in)};
        ADDR_DIG_DIR:      rv = {24'h00_0000, s_q.dig_dir};
        ADDR_ANA_FUNC_SEL: rv = odd_spread(s_q.ana_mode);
        ADDR_ANA_DATA: begin
          rv = {24'h00_0000, readback({2'h0, ana_drv}, {2'h0, s_q.ana_dat}, {2'h0, s_q.ana_in})};
        end
        ADDR_ANA_DIR:      rv = {26'h000_0000, s_q.ana_dir};
        ADDR_DIG_ENABLE:   rv = {24'h00_0000, s_q.dig_en};
        default:           rv = 32'h0000_0000;
      endcase
    end
    // The read word is kept until the next read answer replaces it.
    if (take && req.read) begin
      s_d.rdata = rv;
    end

    // Register writes, byte lanes honoured.
    if (allowed) begin
      case (req.address)
        ADDR_DIG_FUNC_SEL: begin
          wv = merge({16'h0000, s_q.dig_sel}, req.writedata, req.byteenable);
          s_d.dig_sel = wv[15:0];
        end
        ADDR_DIG_PUD: begin
          wv = merge({24'h00_0000, s_q.dig_pud}, req.writedata, req.byteenable);
          s_d.dig_pud = wv[7:0];
        end
        ADDR_DIG_DATA: begin
          wv = merge({24'h00_0000, s_q.dig_dat}, req.writedata, req.byteenable);
          s_d.dig_dat = wv[7:0];
        end
        ADDR_DIG_DIR: begin
          wv = merge({24'h00_0000, s_q.dig_dir}, req.writedata, req.byteenable);
          s_d.dig_dir = wv[7:0];
        end
        ADDR_ANA_FUNC_SEL: begin
          wv = merge(odd_spread(s_q.ana_mode), req.writedata, req.byteenable);
          s_d.ana_mode = odd_gather(wv);
        end
        ADDR_ANA_DATA: begin
          wv = merge({26'h000_0000, s_q.ana_dat}, req.writedata, req.byteenable);
          s_d.ana_dat = wv[5:0];
        end
        ADDR_ANA_DIR: begin
          wv = merge({26'h000_0000, s_q.ana_dir}, req.writedata, req.byteenable);
          s_d.ana_dir = wv[5:0];
        end
        ADDR_DIG_ENABLE: begin
          wv = merge({24'h00_0000, s_q.dig_en}, req.writedata, req.byteenable);
          s_d.dig_en = wv[7:0];
        end
        default: begin
          wv = 32'h0000_0000;
        end
      endcase
    end

    // Digital group pin drive, one registered stage behind the setup.
    for (int p = 0; p < DIG_PINS; p++) begin
      mode = s_q.dig_sel[2*p +: 2];
      cmp  = COMP_FOR_PIN[3*p +: 3];
      s_d.dig_out[p] = 1'b0;
      s_d.dig_oe[p]  = 1'b0;
      if (s_q.dig_en[p]) begin
        case (mode)
          MODE_GPIO: begin
            s_d.dig_out[p] = s_q.dig_dat[p];
            s_d.dig_oe[p]  = s_q.dig_dir[p];
          end
          MODE_COMP: begin
            // Pins without a comparator stay undriven in this mode.
            if (cmp != COMP_NONE) begin
              s_d.dig_out[p] = i_comparator_result[cmp];
              s_d.dig_oe[p]  = 1'b1;
            end
          end
          MODE_RSVD1, MODE_RSVD2: begin
            s_d.dig_oe[p] = 1'b0;
          end
          default: begin
            s_d.dig_oe[p] = 1'b0;
          end
        endcase
      end
    end
    // Pullups are independent of the selected mode.
    s_d.dig_pu = ~s_q.dig_pud;

    // Analog group: converter switch per pin.
    for (int k = 0; k < ANA_PINS; k++) begin
      ch = ANA_PIN_CHAN[4*k +: 4];
      s_d.ana_conv[k] = s_q.ana_mode[ch];
    end
    // Comparator paths share the six dual-use pins. Which destination is
    // live is chosen inside the analog peripherals by software.
    for (int j = 0; j < ANA_DIOS; j++) begin
      ch = ANA_DIO_CHAN[4*j +: 4];
      s_d.ana_cmp[j] = s_q.ana_mode[ch];
    end
    // Digital drive of the analog group. No pullup output exists here.
    s_d.ana_out = s_q.ana_dat;
    s_d.ana_oe  = ana_drv;
  end

  // ==========================================================================
  // State register.
  // ==========================================================================

  // Reset leaves both groups as analog inputs with drivers off.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q          <= '0;
      s_q.dig_sel  <= RST_DIG_FUNC_SEL;
      s_q.dig_pud  <= RST_DIG_PUD;
      s_q.dig_dir  <= RST_DIG_DIR;
      s_q.dig_en   <= RST_DIG_ENABLE;
      s_q.ana_mode <= RST_ANA_MODE;
      s_q.ana_dir  <= RST_ANA_DIR;
      s_q.ana_conv <= 12'hfff;
      s_q.ana_cmp  <= 6'h3f;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================

  // Waitrequest is combinational; everything else is registered.
  assign o_avs_waitrequest   = (req.read || req.write) && !s_q.ack;
  assign o_avs_readdata      = s_q.rdata;
  assign o_dig_pin_out       = s_q.dig_out;
  assign o_dig_pin_oe        = s_q.dig_oe;
  assign o_dig_pullup_en     = s_q.dig_pu;
  assign o_ana_dio_out       = s_q.ana_out;
  assign o_ana_dio_oe        = s_q.ana_oe;
  assign o_ana_to_converter  = s_q.ana_conv;
  assign o_ana_to_comparator = s_q.ana_cmp;

endmodule : comparator_and_analog_pin_mux

// >>> verilog/pin_mux_pkg.sv
// Package with register map, reset values, pin tables and carrier types for the pin mux.
package pin_mux_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each).
  // ==========================================================================
  localparam logic [5:0] ADDR_DIG_FUNC_SEL = 6'h00; // Two mode bits per digital pin.
  localparam logic [5:0] ADDR_DIG_PUD      = 6'h04; // Pullup disable, one bit per pin.
  localparam logic [5:0] ADDR_DIG_DATA     = 6'h08; // Digital-group data.
  localparam logic [5:0] ADDR_DIG_DIR      = 6'h0c; // Digital-group direction, 1 = out.
  localparam logic [5:0] ADDR_ANA_FUNC_SEL = 6'h10; // Odd bits pick analog mode.
  localparam logic [5:0] ADDR_ANA_DATA     = 6'h14; // Analog-group digital data.
  localparam logic [5:0] ADDR_ANA_DIR      = 6'h18; // Analog-group direction, 1 = out.
  localparam logic [5:0] ADDR_DIG_ENABLE   = 6'h1c; // Digital function enable per pin.
  localparam logic [2:0] ADDR_LAST_INDEX   = 3'h7;  // Highest mapped word index.

  // ==========================================================================
  // Widths.
  // ==========================================================================
  localparam int DIG_PINS  = 8;  // Pins in the digital group.
  localparam int ANA_PINS  = 12; // Pins in the analog group.
  localparam int ANA_DIOS  = 6;  // Analog pins with a digital function.
  localparam int ANA_CHANS = 16; // Channel slots in the analog select register.

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [15:0] RST_DIG_FUNC_SEL = 16'h0000; // Mode 0 everywhere.
  localparam logic [7:0]  RST_DIG_PUD      = 8'hff;    // Pullups off: analog state.
  localparam logic [7:0]  RST_DIG_DIR      = 8'h00;    // All inputs.
  localparam logic [7:0]  RST_DIG_ENABLE   = 8'h00;    // Digital function off.
  localparam logic [15:0] RST_ANA_MODE     = 16'hffff; // All channels analog.
  localparam logic [5:0]  RST_ANA_DIR      = 6'h00;    // All inputs.

  // ==========================================================================
  // Peripheral modes of a digital-group pin.
  // ==========================================================================
  localparam logic [1:0] MODE_GPIO  = 2'h0; // Plain digital I/O.
  localparam logic [1:0] MODE_RSVD1 = 2'h1; // Reserved, no function.
  localparam logic [1:0] MODE_RSVD2 = 2'h2; // Reserved, no function.
  localparam logic [1:0] MODE_COMP  = 2'h3; // Comparator result out.

  // Comparator index (0 = comparator 1) per digital pin; 7 means none.
  localparam logic [2:0] COMP_NONE = 3'h7;
  localparam logic [23:0] COMP_FOR_PIN = {3'h4, 3'h7, 3'h3, 3'h2, 3'h1, 3'h5, 3'h0, 3'h7};

  // Channel number of each analog pin (A0,A2,A3,A4,A6,A7,B0,B2,B3,B4,B6,B7).
  localparam logic [47:0] ANA_PIN_CHAN = {4'hf, 4'he, 4'hc, 4'hb, 4'ha, 4'h8,
                                          4'h7, 4'h6, 4'h4, 4'h3, 4'h2, 4'h0};
  // Channel number of each analog digital I/O (2,4,6,10,12,14).
  localparam logic [23:0] ANA_DIO_CHAN = {4'he, 4'hc, 4'ha, 4'h6, 4'h4, 4'h2};

  // ==========================================================================
  // Carrier types.
  // ==========================================================================
  typedef struct packed {
    logic        read;       // Read request.
    logic        write;      // Write request.
    logic [5:0]  address;    // Byte address.
    logic [3:0]  byteenable; // Byte lanes.
    logic [31:0] writedata;  // Write data.
    logic        from_ctrl;  // Request comes from the control CPU.
  } bus_req_type;

  typedef struct packed {
    logic        ack;      // Answer cycle of the bus.
    logic [31:0] rdata;    // Read data.
    logic [15:0] dig_sel;  // Digital mode fields.
    logic [7:0]  dig_pud;  // Pullup disable.
    logic [7:0]  dig_dat;  // Digital output latch.
    logic [7:0]  dig_dir;  // Digital direction.
    logic [7:0]  dig_en;   // Digital function enable.
    logic [15:0] ana_mode; // Analog mode bit per channel.
    logic [5:0]  ana_dat;  // Analog-group output latch.
    logic [5:0]  ana_dir;  // Analog-group direction.
    logic [7:0]  dig_in;   // Sampled digital pins.
    logic [5:0]  ana_in;   // Sampled analog-group digital pins.
    logic [7:0]  dig_out;  // Digital pin drive value.
    logic [7:0]  dig_oe;   // Digital pin enable.
    logic [7:0]  dig_pu;   // Pullup enables.
    logic [5:0]  ana_out;  // Analog-group drive value.
    logic [5:0]  ana_oe;   // Analog-group drive enable.
    logic [11:0] ana_conv; // Converter input switches.
    logic [5:0]  ana_cmp;  // Comparator input switches.
  } state_type;

endpackage : pin_mux_pkg
